// ---- logic/rtca_alarm_config.sv ----
// Functional notes
// - an alarm 2 event sets the alarm 2 event flag in bit 6 of the configuration register.
// - an alarm 1 event sets the alarm 1 event flag in bit 5 of the configuration register.
// - an alarm 0 event sets the alarm 0 event flag in bit 4 of the configuration register.
// - only software clears an event flag, by writing zero; writing one leaves it unchanged.
// - an event flag stays set from its event until software clears it.
// - bit 2 enables alarm 2 to generate events; at zero alarm 2 is off.
// - bit 1 enables alarm 1 to generate events; at zero alarm 1 is off.
// - bit 0 enables alarm 0 to generate events; at zero alarm 0 is off.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module rtca_alarm_config (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// write address channel
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// write data channel
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// write response channel
	output logic      [1:0]  s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// read address channel
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// read data channel
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// timer tick pin, asynchronous
	input  wire logic        tick_pin,
	// events and interrupt
	output logic      [2:0]  alarm_event,
	output logic             irq
);

	////////////////////////////////////////////////////////////////////////////
	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] idx);
		addr_hit = (addr[7:2] == idx[5:0]) && (addr[1:0] == 2'h0);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// write path state
	logic        awready_reg;
	logic        wready_reg;
	logic        aw_full_reg;
	logic        w_full_reg;
	logic [7:0]  waddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0]  wstrb_reg;
	logic        bvalid_reg;
	logic [1:0]  bresp_reg;
	// read path state
	logic        arready_reg;
	logic        rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  rresp_reg;
	// block state
	logic [7:0]  config_reg;
	logic [31:0] counter_reg;
	logic [31:0] match0_reg;
	logic [31:0] match1_reg;
	logic [31:0] match2_reg;
	logic [2:0]  irq_stat_reg;
	logic [2:0]  irq_mask_reg;
	logic        irq_reg;
	logic [2:0]  event_reg;
	// tick synchroniser and filter
	logic        tick_s1_reg;
	logic        tick_s2_reg;
	logic        tick_s3_reg;
	logic        tick_level_reg;

	////////////////////////////////////////////////////////////////////////////
	// write decode
	wire        do_write   = aw_full_reg && w_full_reg && !bvalid_reg;
	wire        wr_counter = do_write && addr_hit(waddr_reg, rtca_pkg::IDX_COUNTER);
	wire        wr_config  = do_write && addr_hit(waddr_reg, rtca_pkg::IDX_CONFIG)
		&& wstrb_reg[0];
	wire        wr_match0  = do_write && addr_hit(waddr_reg, rtca_pkg::IDX_MATCH0);
	wire        wr_match1  = do_write && addr_hit(waddr_reg, rtca_pkg::IDX_MATCH1);
	wire        wr_match2  = do_write && addr_hit(waddr_reg, rtca_pkg::IDX_MATCH2);
	wire        wr_stat    = do_write && addr_hit(waddr_reg, rtca_pkg::IDX_IRQ_STAT)
		&& wstrb_reg[0];
	wire        wr_mask    = do_write && addr_hit(waddr_reg, rtca_pkg::IDX_IRQ_MASK)
		&& wstrb_reg[0];
	wire        wr_mapped  = wr_counter || wr_config || wr_match0 || wr_match1 ||
		wr_match2 || wr_stat || wr_mask ||
		addr_hit(waddr_reg, rtca_pkg::IDX_CONFIG) ||
		addr_hit(waddr_reg, rtca_pkg::IDX_IRQ_STAT) ||
		addr_hit(waddr_reg, rtca_pkg::IDX_IRQ_MASK);

	// byte-lane merge for the 32-bit registers
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// tick edge: counts once the second and third stages agree
	wire tick_agree = (tick_s2_reg == tick_s3_reg);
	wire tick_rise  = tick_agree && tick_s3_reg && !tick_level_reg;

	// alarm comparison
	wire [31:0] count_inc = counter_reg + 32'h0000_0001;
	wire [2:0]  enables   = {config_reg[rtca_pkg::BIT_EN2], config_reg[rtca_pkg::BIT_EN1],
		config_reg[rtca_pkg::BIT_EN0]};
	wire [2:0]  event_hit;

	rtca_alarm_match u_match (
		.advance    (tick_rise),
		.count_inc  (count_inc),
		.enable     (enables),
		.match_flat ({match2_reg, match1_reg, match0_reg}),
		.event_hit  (event_hit)
	);

	// counter: software load wins, then auto clear, then tick
	wire        auto_clear  = event_hit[0] && config_reg[rtca_pkg::BIT_AUTO_CLEAR];
	wire [31:0] counter_next = wr_counter ? merge(counter_reg, wdata_reg, wstrb_reg) :
		auto_clear ? 32'h0000_0000 :
		tick_rise  ? count_inc : counter_reg;

	////////////////////////////////////////////////////////////////////////////
	// configuration next value; the event set wins over a same-cycle clear
	wire [2:0] flags_now  = {config_reg[rtca_pkg::BIT_FLAG2], config_reg[rtca_pkg::BIT_FLAG1],
		config_reg[rtca_pkg::BIT_FLAG0]};
	wire [2:0] flag_wbits = {wdata_reg[rtca_pkg::BIT_FLAG2], wdata_reg[rtca_pkg::BIT_FLAG1],
		wdata_reg[rtca_pkg::BIT_FLAG0]};
	// a written one keeps the flag, a written zero clears it
	wire [2:0] flag_keep  = wr_config ? (flags_now & flag_wbits) : flags_now;
	wire [2:0] flags_next = flag_keep | event_hit;
	wire [3:0] ctrl_next  = wr_config ? wdata_reg[3:0] : config_reg[3:0];
	wire [7:0] config_next = {1'b0, flags_next, ctrl_next};

	// interrupt status, write one to clear, set wins
	wire [2:0] irq_stat_next = (wr_stat ? (irq_stat_reg & ~wdata_reg[2:0]) : irq_stat_reg)
		| event_hit;
	wire [2:0] irq_mask_next = wr_mask ? wdata_reg[2:0] : irq_mask_reg;
	wire       irq_next      = |(irq_stat_next & irq_mask_next);

	////////////////////////////////////////////////////////////////////////////
	// read decode
	wire [7:0] ra = s_axi_araddr;
	wire       rd_hit_cnt  = addr_hit(ra, rtca_pkg::IDX_COUNTER);
	wire       rd_hit_cfg  = addr_hit(ra, rtca_pkg::IDX_CONFIG);
	wire       rd_hit_m0   = addr_hit(ra, rtca_pkg::IDX_MATCH0);
	wire       rd_hit_m1   = addr_hit(ra, rtca_pkg::IDX_MATCH1);
	wire       rd_hit_m2   = addr_hit(ra, rtca_pkg::IDX_MATCH2);
	wire       rd_hit_stat = addr_hit(ra, rtca_pkg::IDX_IRQ_STAT);
	wire       rd_hit_mask = addr_hit(ra, rtca_pkg::IDX_IRQ_MASK);
	wire       rd_mapped   = rd_hit_cnt || rd_hit_cfg || rd_hit_m0 || rd_hit_m1 ||
		rd_hit_m2 || rd_hit_stat || rd_hit_mask;
	wire [31:0] rd_value  = rd_hit_cnt  ? counter_reg :
		rd_hit_cfg  ? {24'h00_0000, 1'b0, config_reg[6:0]} :
		rd_hit_m0   ? match0_reg :
		rd_hit_m1   ? match1_reg :
		rd_hit_m2   ? match2_reg :
		rd_hit_stat ? {29'h0000_0000, irq_stat_reg} :
		rd_hit_mask ? {29'h0000_0000, irq_mask_reg} : 32'h0000_0000;
	wire ar_take = s_axi_arvalid && arready_reg;
	wire aw_take = s_axi_awvalid && awready_reg;
	wire w_take  = s_axi_wvalid && wready_reg;
	wire b_done  = bvalid_reg && s_axi_bready;
	wire r_done  = rvalid_reg && s_axi_rready;

	////////////////////////////////////////////////////////////////////////////
	// write channels
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			awready_reg <= 1'b1;
			aw_full_reg <= 1'b0;
			waddr_reg   <= 8'h00;
		end else begin
			if (aw_take) begin
				awready_reg <= 1'b0;
				aw_full_reg <= 1'b1;
				waddr_reg   <= s_axi_awaddr;
			end else if (do_write) begin
				aw_full_reg <= 1'b0;
			end else if (b_done) begin
				awready_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wready_reg <= 1'b1;
			w_full_reg <= 1'b0;
			wdata_reg  <= 32'h0000_0000;
			wstrb_reg  <= 4'h0;
		end else begin
			if (w_take) begin
				wready_reg <= 1'b0;
				w_full_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end else if (do_write) begin
				w_full_reg <= 1'b0;
			end else if (b_done) begin
				wready_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= rtca_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= wr_mapped ? rtca_pkg::RESP_OKAY : rtca_pkg::RESP_SLVERR;
		end else if (b_done) begin
			bvalid_reg <= 1'b0;
		end
	end

	// read channels; the answer comes one cycle after the address is taken
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0000_0000;
			rresp_reg   <= rtca_pkg::RESP_OKAY;
		end else if (ar_take) begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b1;
			rdata_reg   <= rd_value;
			rresp_reg   <= rd_mapped ? rtca_pkg::RESP_OKAY : rtca_pkg::RESP_SLVERR;
		end else if (r_done) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// tick synchroniser; first stage feeds only the second
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tick_s1_reg    <= 1'b0;
			tick_s2_reg    <= 1'b0;
			tick_s3_reg    <= 1'b0;
			tick_level_reg <= 1'b0;
		end else begin
			tick_s1_reg    <= tick_pin;
			tick_s2_reg    <= tick_s1_reg;
			tick_s3_reg    <= tick_s2_reg;
			tick_level_reg <= tick_agree ? tick_s3_reg : tick_level_reg;
		end
	end

	// block registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			config_reg   <= rtca_pkg::CONFIG_RST;
			counter_reg  <= rtca_pkg::COUNTER_RST;
			irq_stat_reg <= rtca_pkg::IRQ_RST;
			irq_mask_reg <= rtca_pkg::IRQ_RST;
			irq_reg      <= 1'b0;
			event_reg    <= 3'h0;
		end else begin
			config_reg   <= config_next;
			counter_reg  <= counter_next;
			irq_stat_reg <= irq_stat_next;
			irq_mask_reg <= irq_mask_next;
			irq_reg      <= irq_next;
			event_reg    <= event_hit;
		end
	end

	// match values; a partial update while enabled may fire early
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			match0_reg <= rtca_pkg::MATCH_RST;
			match1_reg <= rtca_pkg::MATCH_RST;
			match2_reg <= rtca_pkg::MATCH_RST;
		end else begin
			match0_reg <= wr_match0 ? merge(match0_reg, wdata_reg, wstrb_reg) : match0_reg;
			match1_reg <= wr_match1 ? merge(match1_reg, wdata_reg, wstrb_reg) : match1_reg;
			match2_reg <= wr_match2 ? merge(match2_reg, wdata_reg, wstrb_reg) : match2_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;
	assign alarm_event   = event_reg;
	assign irq           = irq_reg;

endmodule
`default_nettype wire

// ---- logic/rtca_pkg.sv ----
`default_nettype none
package rtca_pkg;
	// register indices, byte address is four times the index
	localparam logic [7:0] IDX_COUNTER   = 8'h00;
	localparam logic [7:0] IDX_CONFIG    = 8'h07;
	localparam logic [7:0] IDX_MATCH0    = 8'h08;
	localparam logic [7:0] IDX_MATCH1    = 8'h09;
	localparam logic [7:0] IDX_MATCH2    = 8'h0a;
	localparam logic [7:0] IDX_IRQ_STAT  = 8'h0c;
	localparam logic [7:0] IDX_IRQ_MASK  = 8'h0d;
	localparam int         ADDR_W        = 8;
	localparam int         NUM_ALARMS    = 3;

	// configuration register field positions
	localparam int BIT_EN0         = 0;
	localparam int BIT_EN1         = 1;
	localparam int BIT_EN2         = 2;
	localparam int BIT_AUTO_CLEAR  = 3;
	localparam int BIT_FLAG0       = 4;
	localparam int BIT_FLAG1       = 5;
	localparam int BIT_FLAG2       = 6;

	// reset values
	localparam logic [7:0]  CONFIG_RST  = 8'h00;
	localparam logic [31:0] COUNTER_RST = 32'h0000_0000;
	localparam logic [31:0] MATCH_RST   = 32'h0000_0000;
	localparam logic [2:0]  IRQ_RST     = 3'h0;

	// axi response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ---- logic/rtca_alarm_match.sv ----
`timescale 1ns/1ps
`default_nettype none
module rtca_alarm_match (
	// counter view
	input  wire logic        advance,
	input  wire logic [31:0] count_inc,
	// alarm setup
	input  wire logic [2:0]  enable,
	input  wire logic [95:0] match_flat,
	// result
	output logic      [2:0]  event_hit
);
	// an alarm fires on the tick that brings the counter onto its match value
	genvar g;
	generate
		for (g = 0; g < rtca_pkg::NUM_ALARMS; g++) begin : g_alarm
			assign event_hit[g] = enable[g] && advance &&
				(count_inc == match_flat[g*32 +: 32]);
		end
	endgenerate
endmodule
`default_nettype wire

// ---- sim/rtca_alarm_config_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module rtca_alarm_config_asserts (
	// clock and reset
	input wire logic        clock,
	input wire logic        rst,
	// bus
	input wire logic        s_axi_awready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// events
	input wire logic [2:0]  alarm_event
);
	// the read address is gone once taken, so keep it for the data beat
	logic [7:0] ar_q;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) ar_q <= 8'h00;
		else if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
	end
	////////////////////////////////////////
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence ar_take; s_axi_arvalid && s_axi_arready; endsequence
	sequence b_wait; s_axi_bvalid && !s_axi_bready; endsequence
	bresp_hold_a: assert property (b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
		else $error("read data changed while waiting");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write address taken during response");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken during response");
	read_lat_a: assert property (ar_take |=> s_axi_rvalid)
		else $error("read answer late");
	unmapped_rd_a: assert property (ar_take and s_axi_araddr == 8'h3c |=>
		s_axi_rresp == rtca_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	cfg_upper_a: assert property (s_axi_rvalid && ar_q == 8'h1c |-> s_axi_rdata[31:7] == 25'h0)
		else $error("config upper bits not zero");
	event_pulse_a: assert property (alarm_event != 3'h0 |=> alarm_event == 3'h0)
		else $error("alarm event longer than one cycle");
endmodule
bind rtca_alarm_config rtca_alarm_config_asserts u_chk (.clock, .rst, .s_axi_awready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .alarm_event);
`default_nettype wire

// ---- sim/rtca_alarm_config_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module rtca_alarm_config_tb;
	logic        clock, rst, tick_pin, irq;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [2:0]  s_axi_awprot, s_axi_arprot, alarm_event, ev_seen;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r, wr_b;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int          error_cnt, total_checks;

	rtca_alarm_config dut (.clock, .rst, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tick_pin,
		.alarm_event, .irq);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// pulses are one cycle wide, so collect them rather than poll
	always @(posedge clock) begin
		if (rst) ev_seen <= 3'h0;
		else ev_seen <= ev_seen | alarm_event;
	end
	////////////////////////////////////////
	task end_sim;
		if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task hang;
		error_cnt++;
		end_sim;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		int i;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge clock);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		wr_b = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (i == 40) hang;
	endtask

	task rd(input logic [7:0] a);
		int i;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge clock);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		rd_d = s_axi_rdata;
		rd_r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (i == 40) hang;
	endtask

	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(rd_d, exp);
	endtask

	// pin levels held well past the three-stage synchroniser
	task tick;
		tick_pin <= 1'b1;
		repeat (4) @(posedge clock);
		tick_pin <= 1'b0;
		repeat (6) @(posedge clock);
	endtask
	////////////////////////////////////////
	task reset_values;
		rd_chk(8'h1c, 32'h0);
		rd(8'h3c);
		chk({30'h0, rd_r}, {30'h0, rtca_pkg::RESP_SLVERR});
		// a misaligned write is refused and leaves the enables alone
		wr(8'h1d, 32'h7);
		chk({30'h0, wr_b}, {30'h0, rtca_pkg::RESP_SLVERR});
		rd_chk(8'h1c, 32'h0);
		// only lane 1 of the counter loads; lane 0 gates the config write
		s_axi_wstrb <= 4'h2;
		wr(8'h00, 32'h1234_5678);
		chk({30'h0, wr_b}, {30'h0, rtca_pkg::RESP_OKAY});
		rd_chk(8'h00, 32'h0000_5600);
		s_axi_wstrb <= 4'he;
		wr(8'h1c, 32'h7);
		rd_chk(8'h1c, 32'h0);
		s_axi_wstrb <= 4'hf;
	endtask

	task alarm_each;
		int n;
		for (n = 0; n < 3; n++) begin
			wr(8'h00, 32'h0);
			wr(8'h1c, 32'h0);
			wr(8'h20 + 8'(4 * n), 32'h2);
			tick;
			tick;
			rd_chk(8'h1c, 32'h0);
			wr(8'h00, 32'h0);
			wr(8'h1c, 32'h1 << n);
			tick;
			tick;
			rd_chk(8'h1c, (32'h1 << n) | (32'h10 << n));
			rd_chk(8'h00, 32'h2);
			chk({29'h0, ev_seen}, (32'h1 << (n + 1)) - 32'h1);
			wr(8'h1c, 32'h70 | (32'h1 << n));
			tick;
			rd_chk(8'h1c, (32'h1 << n) | (32'h10 << n));
			wr(8'h1c, 32'h0);
			rd_chk(8'h1c, 32'h0);
		end
	endtask

	task auto_clear;
		wr(8'h00, 32'h0);
		wr(8'h1c, 32'h9);
		tick;
		tick;
		rd_chk(8'h00, 32'h0);
		rd_chk(8'h1c, 32'h19);
	endtask

	task irq_flow;
		rd_chk(8'h30, 32'h7);
		chk({31'h0, irq}, 32'h0);
		wr(8'h34, 32'h1);
		repeat (2) @(posedge clock);
		chk({31'h0, irq}, 32'h1);
		wr(8'h30, 32'h1);
		repeat (2) @(posedge clock);
		chk({31'h0, irq}, 32'h0);
		rd_chk(8'h30, 32'h6);
	endtask
	////////////////////////////////////////
	initial begin
		{rst, tick_pin, error_cnt, total_checks} = {2'b10, 64'h0};
		{s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = 54'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		s_axi_wstrb = 4'hf;
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		reset_values;
		alarm_each;
		auto_clear;
		irq_flow;
		end_sim;
	end
endmodule
`default_nettype wire
